// ===== inc/pmd_defines.svh
// Offsets, field positions, masks and reset values of the module disable registers
`ifndef PMD_DEFINES_SVH
`define PMD_DEFINES_SVH
`define ADDR_W 4
`define DATA_W 16
`define OFF_CAPCMP 4'h0
`define OFF_MISC 4'h1
`define RST_CAPCMP 16'h0000
`define RST_MISC 16'h0000
`define CAPCMP_MASK 16'hC30F
`define MISC_MASK 16'h07C0
`define BIT_CAPTURE8 15
`define BIT_CAPTURE7 14
`define BIT_CAPTURE2 9
`define BIT_CAPTURE1 8
`define BIT_COMPARE4 3
`define BIT_COMPARE1 0
`define BIT_COMPARATOR 10
`define BIT_CALENDAR 9
`define BIT_PMP 8
`define BIT_CHECKSUM 7
`define BIT_DAC 6
`endif

// ===== inc/pmd_pkg.sv
// Types for the module disable register bank
package pmd_pkg;
  typedef logic [15:0] word_t;
  typedef logic [3:0] addr_t;
  typedef struct packed {
    logic [15:0] capcmp;
    logic [15:0] misc;
    logic [15:0] rdata;
  } regs_state_t;
  typedef struct packed {
    logic [3:0] capture_off;
    logic [3:0] compare_off;
    logic comparator_off;
    logic calendar_clock_off;
    logic parallel_master_port_off;
    logic checksum_unit_off;
    logic dac_unit_off;
  } gate_state_t;
endpackage

// ===== inc/pmd_if.sv
// Register contents handed from the register file to the gate stage
`include "pmd_defines.svh"
interface pmd_if;
  logic [15:0] capcmp;
  logic [15:0] misc;
  modport regs (output capcmp, output misc);
  modport gate (input capcmp, input misc);
endinterface

// ===== core/pmd_gate.sv
// Registered per-unit disable levels decoded from the register contents
`include "pmd_defines.svh"
module pmd_gate
  import pmd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  pmd_if.gate regs_in,
  output gate_state_t gate_q
);
  gate_state_t gate_ff;
  gate_state_t nxt_gate;
  always_comb begin
    nxt_gate = gate_ff;
    nxt_gate.capture_off = {regs_in.capcmp[`BIT_CAPTURE8], regs_in.capcmp[`BIT_CAPTURE7],
      regs_in.capcmp[`BIT_CAPTURE2], regs_in.capcmp[`BIT_CAPTURE1]};
    nxt_gate.compare_off = regs_in.capcmp[`BIT_COMPARE4:`BIT_COMPARE1];
    nxt_gate.comparator_off = regs_in.misc[`BIT_COMPARATOR];
    nxt_gate.calendar_clock_off = regs_in.misc[`BIT_CALENDAR];
    nxt_gate.parallel_master_port_off = regs_in.misc[`BIT_PMP];
    nxt_gate.checksum_unit_off = regs_in.misc[`BIT_CHECKSUM];
    nxt_gate.dac_unit_off = regs_in.misc[`BIT_DAC];
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gate_ff <= '0;
    end else begin
      gate_ff <= nxt_gate;
    end
  end
  assign gate_q = gate_ff;
endmodule

// ===== core/pmd_regs.sv
// Peripheral module disable register bank with per-unit disable outputs
//
// Functional notes
// - Comparator disabled while second register bit 10 is one.
// - Calendar clock disabled while second register bit 9 is one.
// - Parallel master port disabled while second register bit 8 is one.
// - Checksum unit disabled while second register bit 7 is one.
// - DAC disabled while second register bit 6 is one.
// - Unimplemented bits of both registers read as zero.
// - First register bits 15,14,9,8 disable capture channels 8,7,2,1.
// - First register bits 3..0 disable compare channels 4..1.
//
// Decided for this implementation: the register addresses and the strobed register port.
`include "pmd_defines.svh"
module pmd_regs
  import pmd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic [3:0] CAPTURE_OFF,
  output logic [3:0] COMPARE_OFF,
  output logic COMPARATOR_OFF,
  output logic CALENDAR_CLOCK_OFF,
  output logic PARALLEL_MASTER_PORT_OFF,
  output logic CHECKSUM_UNIT_OFF,
  output logic DAC_UNIT_OFF
);
  regs_state_t st_ff;
  regs_state_t nxt_st;
  gate_state_t gate_q;
  pmd_if link ();

  // Bits that exist at each index; unmapped places have none
  function automatic word_t impl_mask(input addr_t a);
    case (a)
      `OFF_CAPCMP: impl_mask = `CAPCMP_MASK;
      `OFF_MISC: impl_mask = `MISC_MASK;
      default: impl_mask = 16'h0000;
    endcase
  endfunction

  // Unmapped addresses read zero and ignore writes
  function automatic word_t read_word(input addr_t a, input regs_state_t s);
    case (a)
      `OFF_CAPCMP: read_word = s.capcmp & `CAPCMP_MASK;
      `OFF_MISC: read_word = s.misc & `MISC_MASK;
      default: read_word = 16'h0000;
    endcase
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 16'h0000;
    if (WR && ADDR == `OFF_CAPCMP) begin
      nxt_st.capcmp = WDATA & impl_mask(ADDR);
    end
    if (WR && ADDR == `OFF_MISC) begin
      nxt_st.misc = WDATA & impl_mask(ADDR);
    end
    if (RD) begin
      nxt_st.rdata = read_word(ADDR, st_ff);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= '{capcmp: `RST_CAPCMP, misc: `RST_MISC, rdata: 16'h0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.capcmp = st_ff.capcmp;
  assign link.misc = st_ff.misc;

  // Extra pipeline stage keeps every off level glitch free for the clock gates
  pmd_gate u_gate (
    .CORE_CLK(CORE_CLK),
    .RST_N(RST_N),
    .regs_in(link.gate),
    .gate_q(gate_q)
  );

  assign RDATA = st_ff.rdata;
  assign CAPTURE_OFF = gate_q.capture_off;
  assign COMPARE_OFF = gate_q.compare_off;
  assign COMPARATOR_OFF = gate_q.comparator_off;
  assign CALENDAR_CLOCK_OFF = gate_q.calendar_clock_off;
  assign PARALLEL_MASTER_PORT_OFF = gate_q.parallel_master_port_off;
  assign CHECKSUM_UNIT_OFF = gate_q.checksum_unit_off;
  assign DAC_UNIT_OFF = gate_q.dac_unit_off;

  // Off levels trail a write by two edges because of the gate stage
  a_comparator_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_MISC
    |-> ##2 COMPARATOR_OFF == $past(WDATA[`BIT_COMPARATOR], 2))
    else $error("comparator off level wrong");
  a_calendar_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_MISC
    |-> ##2 CALENDAR_CLOCK_OFF == $past(WDATA[`BIT_CALENDAR], 2))
    else $error("calendar off level wrong");
  a_pmp_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_MISC
    |-> ##2 PARALLEL_MASTER_PORT_OFF == $past(WDATA[`BIT_PMP], 2))
    else $error("parallel port off level wrong");
  a_checksum_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_MISC
    |-> ##2 CHECKSUM_UNIT_OFF == $past(WDATA[`BIT_CHECKSUM], 2))
    else $error("checksum off level wrong");
  a_dac_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_MISC
    |-> ##2 DAC_UNIT_OFF == $past(WDATA[`BIT_DAC], 2))
    else $error("dac off level wrong");
  a_capture_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_CAPCMP
    |-> ##2 CAPTURE_OFF == {$past(WDATA[`BIT_CAPTURE8], 2), $past(WDATA[`BIT_CAPTURE7], 2),
      $past(WDATA[`BIT_CAPTURE2], 2), $past(WDATA[`BIT_CAPTURE1], 2)})
    else $error("capture off levels wrong");
  a_compare_follows: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_CAPCMP
    |-> ##2 COMPARE_OFF == $past(WDATA[`BIT_COMPARE4:`BIT_COMPARE1], 2))
    else $error("compare off levels wrong");

  a_capcmp_masked: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_CAPCMP
    |=> st_ff.capcmp == ($past(WDATA) & `CAPCMP_MASK))
    else $error("capture compare word not masked");
  a_misc_masked: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR == `OFF_MISC
    |=> st_ff.misc == ($past(WDATA) & `MISC_MASK))
    else $error("misc word not masked");
  a_unmapped_ignored: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WR && ADDR > `OFF_MISC
    |=> $stable(st_ff.capcmp) && $stable(st_ff.misc))
    else $error("unmapped write changed a register");
  a_read_unimpl_zero: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    RD
    |=> (RDATA & ~impl_mask($past(ADDR))) == 16'h0000)
    else $error("unimplemented bit read nonzero");
  a_read_capcmp_word: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    RD && ADDR == `OFF_CAPCMP
    |=> RDATA == $past(st_ff.capcmp))
    else $error("capture compare read wrong");
  a_read_misc_word: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    RD && ADDR == `OFF_MISC
    |=> RDATA == $past(st_ff.misc))
    else $error("misc read wrong");

  // Reset is asynchronous, so the last three look at the second edge of a low level; a_reset_enabled checks the edge where RST_N rises
  a_reset_enabled: assert property (
    @(posedge CORE_CLK)
    $rose(RST_N)
    |-> CAPTURE_OFF == 4'h0 && COMPARE_OFF == 4'h0 && !DAC_UNIT_OFF)
    else $error("unit disabled after reset");
  a_reset_regs_clear: assert property (
    @(posedge CORE_CLK)
    !RST_N ##1 !RST_N
    |-> st_ff.capcmp == `RST_CAPCMP && st_ff.misc == `RST_MISC)
    else $error("register not cleared by reset");
  a_reset_units_on: assert property (
    @(posedge CORE_CLK)
    !RST_N ##1 !RST_N
    |-> CAPTURE_OFF == 4'h0 && COMPARE_OFF == 4'h0 && !COMPARATOR_OFF && !CALENDAR_CLOCK_OFF
      && !PARALLEL_MASTER_PORT_OFF && !CHECKSUM_UNIT_OFF && !DAC_UNIT_OFF)
    else $error("unit left disabled in reset");
  a_reset_read_zero: assert property (
    @(posedge CORE_CLK)
    !RST_N ##1 !RST_N
    |-> RDATA == 16'h0000)
    else $error("read data not cleared by reset");

  // A unit's off level may only move two edges after a write to its register
  a_off_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !WR ##1 !WR
    |-> ##1 $stable(COMPARATOR_OFF) && $stable(CAPTURE_OFF))
    else $error("off level changed without write");
  a_capture_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !(WR && ADDR == `OFF_CAPCMP)
    |-> ##2 $stable(CAPTURE_OFF))
    else $error("capture off level moved without write");
  a_compare_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !(WR && ADDR == `OFF_CAPCMP)
    |-> ##2 $stable(COMPARE_OFF))
    else $error("compare off level moved without write");
  a_calendar_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !(WR && ADDR == `OFF_MISC)
    |-> ##2 $stable(CALENDAR_CLOCK_OFF))
    else $error("calendar off level moved without write");
  a_pmp_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !(WR && ADDR == `OFF_MISC)
    |-> ##2 $stable(PARALLEL_MASTER_PORT_OFF))
    else $error("parallel port off level moved without write");
  a_checksum_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !(WR && ADDR == `OFF_MISC)
    |-> ##2 $stable(CHECKSUM_UNIT_OFF))
    else $error("checksum off level moved without write");
  a_dac_held: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !(WR && ADDR == `OFF_MISC)
    |-> ##2 $stable(DAC_UNIT_OFF))
    else $error("dac off level moved without write");

  c_misc_write: cover property (@(posedge CORE_CLK) WR && ADDR == `OFF_MISC && WDATA[10]);
  c_capcmp_write: cover property (@(posedge CORE_CLK) WR && ADDR == `OFF_CAPCMP);
  c_read_back: cover property (@(posedge CORE_CLK) WR ##1 RD);
  c_unmapped_read: cover property (@(posedge CORE_CLK) RD && ADDR > `OFF_MISC);
  c_unmapped_write: cover property (@(posedge CORE_CLK) WR && ADDR > `OFF_MISC);
endmodule

// ===== tb/peripheral_module_disable_regs_test.sv
// Self-checking bench for the module disable register bank
module peripheral_module_disable_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] rb; logic [15:0] offs;} row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [15:0] rdata;
  logic [3:0] cap_off;
  logic [3:0] cmp_off;
  logic comparator_off, calendar_off, pmp_off, crc_off, dac_off;
  int num_errors = 0;
  int checked = 0;
  // Address, write data, read-back, then off levels as {capture, compare, five units}
  row_t rows [10] = '{
    '{4'h0, 16'hFFFF, 16'hC30F, 16'h1FE0}, '{4'h1, 16'hFFFF, 16'h07C0, 16'h1FFF},
    '{4'h0, 16'h8000, 16'h8000, 16'h101F}, '{4'h1, 16'h0400, 16'h0400, 16'h1010},
    '{4'h0, 16'h0001, 16'h0001, 16'h0030}, '{4'h1, 16'h0040, 16'h0040, 16'h0021},
    '{4'h0, 16'h4201, 16'h4201, 16'h0C21}, '{4'h1, 16'h0380, 16'h0380, 16'h0C2E},
    '{4'h0, 16'h3CF8, 16'h0008, 16'h010E}, '{4'h1, 16'hF83F, 16'h0000, 16'h0100}};
  wire [15:0] offs = {3'b000, cap_off, cmp_off, comparator_off, calendar_off, pmp_off,
                      crc_off, dac_off};
  always #12.5 core_clk = ~core_clk;
  pmd_regs i_pmd_regs (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr_strobe), .RD(rd_strobe), .RDATA(rdata), .CAPTURE_OFF(cap_off),
    .COMPARE_OFF(cmp_off), .COMPARATOR_OFF(comparator_off),
    .CALENDAR_CLOCK_OFF(calendar_off), .PARALLEL_MASTER_PORT_OFF(pmp_off),
    .CHECKSUM_UNIT_OFF(crc_off), .DAC_UNIT_OFF(dac_off));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr_strobe <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe, so sample there
  task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    rd_strobe <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
  initial begin
    logic [15:0] v;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_read(4'h0, v);
    chk(v, 16'h0000);
    reg_read(4'h1, v);
    chk(v, 16'h0000);
    chk(offs, 16'h0000);
    $display("Test reset values done");
    for (int i = 0; i < 10; i++) begin
      reg_write(rows[i].a, rows[i].d);
      @(posedge core_clk);
      #1 chk(offs, rows[i].offs);
      reg_read(rows[i].a, v);
      chk(v, rows[i].rb);
    end
    $display("Test table rows done");
    reg_write(4'h0, 16'h0006);
    reg_write(4'h2, 16'hFFFF);
    reg_read(4'h2, v);
    chk(v, 16'h0000);
    reg_read(4'h0, v);
    chk(v, 16'h0006);
    reg_read(4'h1, v);
    chk(v, 16'h0000);
    $display("Test unmapped place done");
    // Read straight after a write must already see the new word
    @(posedge core_clk);
    wr_strobe <= 1'b1;
    addr <= 4'h1;
    wdata <= 16'h0200;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b1;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1 chk(rdata, 16'h0200);
    chk(offs, 16'h00C8);
    $display("Test back to back done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    #1 chk(offs, 16'h0000);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_read(4'h1, v);
    chk(v, 16'h0000);
    reg_read(4'h0, v);
    chk(v, 16'h0000);
    $display("Test mid-run reset done");
    finish_test();
  end
endmodule
